// *** dir_defs.vh ***
// Constants for the digital input routing block
`ifndef DIR_DEFS_VH
`define DIR_DEFS_VH
// Timing
`define DIR_CLK_MHZ        100
`define DIR_SAMPLE_US      1000
`define DIR_SAMPLE_CYC     (`DIR_SAMPLE_US * `DIR_CLK_MHZ)
`define DIR_CNT_W          17
// Register byte offsets
`define DIR_OFS_SFEN       8'h00
`define DIR_OFS_PINCFG     8'h04
`define DIR_OFS_ROUTED     8'h08
`define DIR_OFS_RAW        8'h0c
`define DIR_OFS_ISTAT      8'h10
`define DIR_OFS_IMASK      8'h14
`define DIR_OFS_FRO        8'h18
`define DIR_ROUTE_BIT      7
// Field positions
`define DIR_SF_NEG_BIT     0
`define DIR_SF_POS_BIT     1
`define DIR_SF_HOME_BIT    2
`define DIR_SF_ILK_BIT     3
`define DIR_PIN_LVL_BIT    0
`define DIR_PIN_PU_LSB     16
`define DIR_IRQ_ILK_BIT    0
`define DIR_IRQ_CHG_BIT    1
`define DIR_IRQ_W          2
// Reset values
`define DIR_RST_SFEN       4'h0
`define DIR_RST_LVL        1'b0
`define DIR_RST_PU         16'h0000
`define DIR_RST_FRO        16'h0000
`define DIR_RST_ROUTE      8'h00
// Source codes
`define DIR_SRC_PHYS_LO    7'h01
`define DIR_SRC_PHYS_HI    7'h10
`define DIR_SRC_HALL_U     7'h41
`define DIR_SRC_ENC_I      7'h46
`define DIR_SRC_BLK_N      7'h51
`define DIR_SRC_BLK_P      7'h52
`define DIR_SRC_ANALOG     7'h5a
`define DIR_SRC_INV_BIT    7
// Bus answers
`define DIR_RESP_OKAY      2'b00
`define DIR_RESP_SLVERR    2'b10
`endif

// *** dir_input_routing.v ***
// Digital input sampling, routing and interlock with AXI4-Lite registers
`timescale 1ns/10ps
`include "dir_defs.vh"

// Functional notes
// - Sample all inputs once per millisecond
// - Pull-down: open or grounded pin reads 0
// - Pull-up: open reads 1, grounded reads 0
// - Level select picks 5 V or 24 V threshold
// - Show routed word and raw input status
// - Bits 0-3: limits, home, interlock release
// - Each routed bit uses its own source
// - Route entry n drives bit n
// - Code 0 is zero, 1-16 physical inputs
// - Hall, encoder, block and analog source codes
// - Code plus 0x80 inverts the source
// - Interlock low forces error and drops motion permit
// - Interlock ignored unless enable bit 3 set
module dir_input_routing #(
   parameter SAMPLE_CYCLES = `DIR_SAMPLE_CYC
) (
   input  wire        mclk,            // System clock, 100 MHz
   input  wire        rst_n,           // Asynchronous reset, active low
   input  wire [15:0] pin_conn,        // Pin is driven externally (not open)
   input  wire [15:0] pin_ge5,         // Pin voltage at or above 5 V threshold
   input  wire [15:0] pin_ge24,        // Pin voltage at or above 24 V threshold
   input  wire [2:0]  hall_uvw,        // Hall inputs U, V, W
   input  wire [2:0]  enc_abi,         // Encoder A, B, index
   input  wire        block_neg,       // Negative block signal
   input  wire        block_pos,       // Positive block signal
   input  wire        analog_dig,      // Analog input as digital level
   input  wire [7:0]  s_axi_awaddr,    // Write address
   input  wire        s_axi_awvalid,   // Write address valid
   output wire        s_axi_awready,   // Write address ready
   input  wire [31:0] s_axi_wdata,     // Write data
   input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
   input  wire        s_axi_wvalid,    // Write data valid
   output wire        s_axi_wready,    // Write data ready
   output reg  [1:0]  s_axi_bresp,     // Write response
   output reg         s_axi_bvalid,    // Write response valid
   input  wire        s_axi_bready,    // Write response ready
   input  wire [7:0]  s_axi_araddr,    // Read address
   input  wire        s_axi_arvalid,   // Read address valid
   output wire        s_axi_arready,   // Read address ready
   output reg  [31:0] s_axi_rdata,     // Read data
   output reg  [1:0]  s_axi_rresp,     // Read response
   output reg         s_axi_rvalid,    // Read data valid
   input  wire        s_axi_rready,    // Read data ready
   output reg         limit_neg,       // Negative limit switch active
   output reg         limit_pos,       // Positive limit switch active
   output reg         home_switch,     // Home switch active
   output reg         motion_permit,   // Motion allowed by interlock
   output reg         error_state,     // Interlock error state
   output reg  [15:0] fault_reaction,  // Configured fault reaction option
   output wire        irq              // Interrupt, active high level
);

   localparam integer          CNT_LAST_I = SAMPLE_CYCLES - 1;
   localparam [`DIR_CNT_W-1:0] CNT_LAST   = CNT_LAST_I[`DIR_CNT_W-1:0];

   // Source selection for one routed bit
   function route_sel;
      input [7:0]  code;
      input [15:0] phys;
      input [8:0]  misc;
      reg   [6:0]  b;
      reg   [3:0]  pidx;
      reg   [2:0]  midx;
      reg          v;
      begin
         b = code[6:0];
         pidx = code[3:0] - 4'h1;
         midx = code[2:0] - 3'h1;
         v = 1'b0;
         if (b >= `DIR_SRC_PHYS_LO && b <= `DIR_SRC_PHYS_HI)
            v = phys[pidx];
         else if (b >= `DIR_SRC_HALL_U && b <= `DIR_SRC_ENC_I)
            v = misc[midx];
         else if (b == `DIR_SRC_BLK_N)
            v = misc[6];
         else if (b == `DIR_SRC_BLK_P)
            v = misc[7];
         else if (b == `DIR_SRC_ANALOG)
            v = misc[8];
         route_sel = v ^ code[`DIR_SRC_INV_BIT];
      end
   endfunction

   // Register map decode, shared by read and write paths
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = a[`DIR_ROUTE_BIT] ||
                     a == `DIR_OFS_SFEN  || a == `DIR_OFS_PINCFG ||
                     a == `DIR_OFS_ROUTED || a == `DIR_OFS_RAW ||
                     a == `DIR_OFS_ISTAT || a == `DIR_OFS_IMASK ||
                     a == `DIR_OFS_FRO;
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0]  strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k])
               merge[k*8 +: 8] = din[k*8 +: 8];
         end
      end
   endfunction

   reg [`DIR_CNT_W-1:0] cnt_ff;
   reg                  tick_ff;
   reg [3:0]            sfen_ff;
   reg                  lvl_ff;
   reg [15:0]           pu_ff;
   reg [15:0]           fro_ff;
   reg [7:0]            route_ff [0:31];
   reg [31:0]           routed_ff;
   reg [31:0]           raw_ff;
   reg [`DIR_IRQ_W-1:0] istat_ff;
   reg [`DIR_IRQ_W-1:0] imask_ff;
   reg                  aw_full_ff;
   reg [7:0]            awaddr_ff;
   reg                  w_full_ff;
   reg [31:0]           wdata_ff;
   reg [3:0]            wstrb_ff;

   wire [15:0]           phys_lvl;
   wire [8:0]            misc_lvl;
   wire [31:0]           nxt_routed;
   wire [31:0]           nxt_raw;
   wire                  do_wr;
   wire                  do_rd;
   wire                  ilk_low;
   wire [`DIR_IRQ_W-1:0] evt;
   reg  [`DIR_IRQ_W-1:0] w1c;
   reg  [31:0]           rd_mux;
   wire [31:0]           pin_merged;
   wire [31:0]           fro_merged;

   // Electrical conversion of each physical pin
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
         assign phys_lvl[gi] = pin_conn[gi] ?
                               (lvl_ff ? pin_ge24[gi] : pin_ge5[gi]) :
                               pu_ff[gi];
      end
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_route
         assign nxt_routed[gi] = route_sel(route_ff[gi], phys_lvl, misc_lvl);
      end
   endgenerate

   assign misc_lvl = {analog_dig, block_pos, block_neg, enc_abi, hall_uvw};
   assign nxt_raw  = {7'h00, misc_lvl, phys_lvl};

   // Byte-lane merges keep the lanes that a write leaves untouched
   assign pin_merged = merge({pu_ff, 16'h0000}, wdata_ff, wstrb_ff);
   assign fro_merged = merge({16'h0000, fro_ff}, wdata_ff, wstrb_ff);

   // Millisecond sample tick
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff  <= {`DIR_CNT_W{1'b0}};
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (cnt_ff == CNT_LAST);
         if (cnt_ff == CNT_LAST)
            cnt_ff <= {`DIR_CNT_W{1'b0}};
         else
            cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign ilk_low = sfen_ff[`DIR_SF_ILK_BIT] & ~nxt_routed[3];
   assign evt[`DIR_IRQ_ILK_BIT] = tick_ff & ilk_low & ~error_state;
   assign evt[`DIR_IRQ_CHG_BIT] = tick_ff & (nxt_routed != routed_ff);

   // Sampled words and special functions
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         routed_ff     <= 32'h0000_0000;
         raw_ff        <= 32'h0000_0000;
         limit_neg     <= 1'b0;
         limit_pos     <= 1'b0;
         home_switch   <= 1'b0;
         motion_permit <= 1'b1;
         error_state   <= 1'b0;
      end else if (tick_ff) begin
         routed_ff     <= nxt_routed;
         raw_ff        <= nxt_raw;
         limit_neg     <= sfen_ff[`DIR_SF_NEG_BIT] & nxt_routed[0];
         limit_pos     <= sfen_ff[`DIR_SF_POS_BIT] & nxt_routed[1];
         home_switch   <= sfen_ff[`DIR_SF_HOME_BIT] & nxt_routed[2];
         motion_permit <= ~ilk_low;
         error_state   <= ilk_low;
      end
   end

   // AXI4-Lite write channel
   assign s_axi_awready = ~aw_full_ff & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full_ff & ~s_axi_bvalid;
   assign do_wr         = aw_full_ff & w_full_ff & ~s_axi_bvalid;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_ff   <= 1'b0;
         awaddr_ff    <= 8'h00;
         w_full_ff    <= 1'b0;
         wdata_ff     <= 32'h0000_0000;
         wstrb_ff     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DIR_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_full_ff   <= 1'b0;
            w_full_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(awaddr_ff) ? `DIR_RESP_OKAY : `DIR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @* begin
      w1c = {`DIR_IRQ_W{1'b0}};
      if (do_wr && awaddr_ff == `DIR_OFS_ISTAT && wstrb_ff[0])
         w1c = wdata_ff[`DIR_IRQ_W-1:0];
   end

   // Configuration registers
   integer ri;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sfen_ff        <= `DIR_RST_SFEN;
         lvl_ff         <= `DIR_RST_LVL;
         pu_ff          <= `DIR_RST_PU;
         fro_ff         <= `DIR_RST_FRO;
         imask_ff       <= {`DIR_IRQ_W{1'b0}};
         istat_ff       <= {`DIR_IRQ_W{1'b0}};
         fault_reaction <= `DIR_RST_FRO;
         for (ri = 0; ri < 32; ri = ri + 1)
            route_ff[ri] <= `DIR_RST_ROUTE;
      end else begin
         // New events win over a same-cycle clear
         istat_ff       <= (istat_ff & ~w1c) | evt;
         fault_reaction <= fro_ff;
         if (do_wr) begin
            if (awaddr_ff[`DIR_ROUTE_BIT]) begin
               if (wstrb_ff[0])
                  route_ff[awaddr_ff[6:2]] <= wdata_ff[7:0];
            end else begin
               case (awaddr_ff)
                  `DIR_OFS_SFEN: begin
                     if (wstrb_ff[0])
                        sfen_ff <= wdata_ff[3:0];
                  end
                  `DIR_OFS_PINCFG: begin
                     if (wstrb_ff[0])
                        lvl_ff <= wdata_ff[`DIR_PIN_LVL_BIT];
                     pu_ff <= pin_merged[`DIR_PIN_PU_LSB +: 16];
                  end
                  `DIR_OFS_IMASK: begin
                     if (wstrb_ff[0])
                        imask_ff <= wdata_ff[`DIR_IRQ_W-1:0];
                  end
                  `DIR_OFS_FRO: begin
                     fro_ff <= fro_merged[15:0];
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   assign irq = |(istat_ff & imask_ff);

   // AXI4-Lite read channel
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_rd         = s_axi_arvalid & s_axi_arready;

   always @* begin
      rd_mux = 32'h0000_0000;
      if (s_axi_araddr[`DIR_ROUTE_BIT]) begin
         rd_mux = {24'h000000, route_ff[s_axi_araddr[6:2]]};
      end else begin
         case (s_axi_araddr)
            `DIR_OFS_SFEN:   rd_mux = {28'h0000000, sfen_ff};
            `DIR_OFS_PINCFG: rd_mux = {pu_ff, 15'h0000, lvl_ff};
            `DIR_OFS_ROUTED: rd_mux = routed_ff;
            `DIR_OFS_RAW:    rd_mux = raw_ff;
            `DIR_OFS_ISTAT:  rd_mux = {30'h00000000, istat_ff};
            `DIR_OFS_IMASK:  rd_mux = {30'h00000000, imask_ff};
            `DIR_OFS_FRO:    rd_mux = {16'h0000, fro_ff};
            default:         rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `DIR_RESP_OKAY;
      end else if (do_rd) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= is_mapped(s_axi_araddr) ? `DIR_RESP_OKAY : `DIR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // dir_input_routing

// *** dir_input_routing_monitor.sv ***
// Bus handshake and output timing checks for the input routing block
`timescale 1ns/10ps
`include "dir_defs.vh"
module dir_input_routing_monitor #(
   parameter SAMPLE_CYCLES = 16
) (
   input wire        mclk,          // Clock
   input wire        rst_n,         // Reset, active low
   input wire [7:0]  s_axi_araddr,  // Read address
   input wire        s_axi_arvalid, // Read address valid
   input wire        s_axi_arready, // Read address ready
   input wire [31:0] s_axi_rdata,   // Read data
   input wire [1:0]  s_axi_rresp,   // Read response
   input wire        s_axi_rvalid,  // Read valid
   input wire        s_axi_rready,  // Read ready
   input wire        s_axi_awready, // Write address ready
   input wire        s_axi_wready,  // Write data ready
   input wire [1:0]  s_axi_bresp,   // Write response
   input wire        s_axi_bvalid,  // Write response valid
   input wire        s_axi_bready,  // Write response ready
   input wire        limit_neg,     // Negative limit
   input wire        limit_pos,     // Positive limit
   input wire        home_switch,   // Home
   input wire        motion_permit, // Permit
   input wire        error_state    // Error
);
   reg  [`DIR_CNT_W-1:0] gap_ff;
   reg  [3:0]            prev_ff;
   wire [3:0]            outs = {limit_neg, limit_pos, home_switch, motion_permit};
   wire                  chg  = outs != prev_ff;
   // Cycles since the last change of the switch outputs
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap_ff  <= {`DIR_CNT_W{1'b0}};
         prev_ff <= 4'h1;
      end else begin
         prev_ff <= outs;
         if (chg) gap_ff <= {`DIR_CNT_W{1'b0}};
         else if (gap_ff != {`DIR_CNT_W{1'b1}}) gap_ff <= gap_ff + 1'b1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read answer not held");
   property p_rd_one; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rd_one: assert property (p_rd_one) else $error("read accepted while busy");
   property p_rd_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rd_drop: assert property (p_rd_drop) else $error("read valid stuck");
   property p_rd_err;
      s_axi_arvalid && s_axi_arready && s_axi_araddr inside {[8'h1c:8'h7c]}
         |=> s_axi_rresp == `DIR_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write answer not held");
   property p_wr_one; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_wr_one: assert property (p_wr_one) else $error("write accepted while busy");
   property p_err; error_state == !motion_permit; endproperty
   a_err: assert property (p_err) else $error("error and permit disagree");
   property p_tick; chg |-> gap_ff >= SAMPLE_CYCLES - 1; endproperty
   a_tick: assert property (p_tick) else $error("outputs change between samples");
endmodule // dir_input_routing_monitor

bind dir_input_routing dir_input_routing_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_mon (.*);

// *** dir_input_routing_tb.sv ***
// Self-checking bench for the digital input routing block
`timescale 1ns/10ps
`include "dir_defs.vh"
module dir_input_routing_tb;
   localparam SC = 16;
   reg         mclk = 1'b0, rst_n = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire        limit_neg, limit_pos, home_switch, motion_permit, error_state;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] fault_reaction, pin_conn, pin_ge5, pin_ge24;
   wire [2:0]  hall_uvw, enc_abi;
   wire        block_neg, block_pos, analog_dig;
   reg  [31:0] volts = 32'h0, vt, exp_w;
   reg  [8:0]  misc = 9'h0, mt;
   reg  [15:0] pins, pu;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   integer miscompares = 0, n_checks = 0, i, j;
`define CHK(nm, e, g) begin logic [33:0] ce; ce = (e); n_checks++; if ((g) !== ce) begin \
   miscompares++; $display("[ERR] %s exp %h got %h", nm, ce, g); end end
   always #5 mclk = !mclk;
   dir_input_routing #(.SAMPLE_CYCLES(SC)) dut (.*);
   dir_pin_model u_pins (.mclk(mclk), .volts(volts), .misc(misc), .pin_conn(pin_conn),
      .pin_ge5(pin_ge5), .pin_ge24(pin_ge24), .hall_uvw(hall_uvw), .enc_abi(enc_abi),
      .block_neg(block_neg), .block_pos(block_pos), .analog_dig(analog_dig));
   task stop_test; begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   end endtask
   task tmo; begin
      miscompares++;
      $display("[ERR] handshake exp done got timeout");
      stop_test;
   end endtask
   task xfer(input wr, input [7:0] a, input [31:0] d, input [1:0] r);
      reg       t_a, t_w, t_r;
      reg [1:0] dly;
      integer   k;
      begin
         dly = $urandom;
         if (wr) begin
            bq.push_back(r);
            s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
         end else begin
            rq.push_back({r, d});
            s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
         end
         for (k = 0; k < 64; k++) begin
            // A late answer-ready makes the slave hold its answer
            if (k == dly) begin s_axi_bready <= wr; s_axi_rready <= !wr; end
            #1;
            t_a = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);
            t_w = s_axi_wvalid & s_axi_wready;
            t_r = wr ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
            @(posedge mclk);
            if (t_a) begin s_axi_awvalid <= 1'b0; s_axi_arvalid <= 1'b0; end
            if (t_w) s_axi_wvalid <= 1'b0;
            if (t_r) begin s_axi_bready <= 1'b0; s_axi_rready <= 1'b0; k = 99; end
         end
         if (k == 64) tmo;
         @(posedge mclk);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d); xfer(1'b1, a, d, `DIR_RESP_OKAY); endtask
   task rd(input [7:0] a, input [31:0] d); xfer(1'b0, a, d, `DIR_RESP_OKAY); endtask
   task settle; repeat (2 * SC + 4) @(posedge mclk); endtask
   task chk_out(input [5:0] e); begin
      #1 `CHK("outputs", e, {limit_neg, limit_pos, home_switch, motion_permit, error_state, irq})
      @(posedge mclk);
   end endtask
   // Scoreboard: bus answers against the oldest note
   always @(posedge mclk) begin
      if (s_axi_bvalid && s_axi_bready) `CHK("bresp", bq.pop_front(), s_axi_bresp)
      if (s_axi_rvalid && s_axi_rready) `CHK("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata})
   end
   function pin_bit(input [1:0] v, input p, input l);
      pin_bit = v == 2'h0 ? p : v == 2'h1 ? 1'b0 : v == 2'h2 ? !l : 1'b1;
   endfunction
   function [7:0] code_of(input integer k);
      integer b;
      begin
         b = k % 26;
         code_of = b <= 16 ? b : b <= 22 ? 8'h41 + b - 17 : b == 23 ? 8'h51 : b == 24 ? 8'h52 : 8'h5a;
         if (k >= 26) code_of = code_of | 8'h80;
      end
   endfunction
   function src(input [7:0] c);
      reg [6:0] b;
      begin
         b = c[6:0];
         src = b == 7'h0 ? 1'b0 : b <= 7'h10 ? pins[b-1] : (b >= 7'h41 && b <= 7'h46) ?
            misc[b-7'h41] : b == 7'h51 ? misc[6] : b == 7'h52 ? misc[7] : b == 7'h5a ? misc[8] : 1'b0;
         src = src ^ c[7];
      end
   endfunction
   initial begin #500000; tmo; end
   initial begin
      void'($urandom(32'h31f1));
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk_out(6'b000100);
      for (i = 0; i < 7; i++) rd(i * 4, 32'h0);
      rd(8'h80, 32'h0);
      xfer(1'b0, 8'h20, 32'h0, `DIR_RESP_SLVERR);
      xfer(1'b1, 8'h40, 32'h1, `DIR_RESP_SLVERR);
      wr(`DIR_OFS_FRO, 32'ha5c3);
      #1 `CHK("fault_reaction", 16'ha5c3, fault_reaction)
      @(posedge mclk);
      for (i = 0; i < 4; i++) begin
         vt = $urandom; mt = $urandom; pu = $urandom;
         volts <= vt; misc <= mt;
         wr(`DIR_OFS_PINCFG, {pu, 15'h0, i[0]});
         for (j = 0; j < 16; j++) pins[j] = pin_bit(vt[2*j+:2], pu[j], i[0]);
         settle;
         rd(`DIR_OFS_RAW, {7'h0, mt, pins});
         exp_w = 32'h0;
         for (j = 0; j < 13; j++) begin
            wr(8'h80 + j * 4, code_of(13 * i + j));
            exp_w[j] = src(code_of(13 * i + j));
         end
         settle;
         rd(`DIR_OFS_ROUTED, exp_w);
      end
      wr(`DIR_OFS_IMASK, 32'h1);
      for (j = 0; j < 4; j++) wr(8'h80 + j * 4, j[0] ? 8'h00 : 8'h80);
      wr(`DIR_OFS_SFEN, 32'h7);
      settle;
      chk_out(6'b101100);
      wr(`DIR_OFS_ISTAT, 32'h3);
      wr(`DIR_OFS_SFEN, 32'h8);
      settle;
      chk_out(6'b000011);
      rd(`DIR_OFS_ISTAT, 32'h1);
      wr(`DIR_OFS_ISTAT, 32'h1);
      chk_out(6'b000010);
      wr(8'h8c, 32'h80);
      settle;
      chk_out(6'b000100);
      stop_test;
   end
endmodule // dir_input_routing_tb

// *** dir_pin_model.sv ***
// Behavioural model of the switches and sensors wired to the inputs
`timescale 1ns/10ps
module dir_pin_model (
   input  wire        mclk,       // Clock for the idle pattern
   input  wire [31:0] volts,      // Two bits a pin: 0 open, 1 gnd, 2 5 V, 3 24 V
   input  wire [8:0]  misc,       // Analog, blocks, encoder, Hall levels
   output reg  [15:0] pin_conn,   // Pin driven
   output reg  [15:0] pin_ge5,    // At or above 5 V
   output reg  [15:0] pin_ge24,   // At or above 24 V
   output wire [2:0]  hall_uvw,   // Hall U V W
   output wire [2:0]  enc_abi,    // Encoder A B index
   output wire        block_neg,  // Negative block
   output wire        block_pos,  // Positive block
   output wire        analog_dig  // Analog level
);
   reg     tgl_ff = 1'b0;
   integer i;
   always @(posedge mclk) tgl_ff <= !tgl_ff;
   // An open pin has no defined comparator level, so it wanders
   always @* begin
      for (i = 0; i < 16; i = i + 1) begin
         pin_conn[i] = volts[2*i+:2] != 2'h0;
         pin_ge5[i]  = pin_conn[i] ? volts[2*i+1] : tgl_ff;
         pin_ge24[i] = pin_conn[i] ? volts[2*i+:2] == 2'h3 : !tgl_ff;
      end
   end
   assign {analog_dig, block_pos, block_neg, enc_abi, hall_uvw} = misc;
endmodule // dir_pin_model
